/* File: hw/thd_alarm.sv */
// Current total harmonic distortion alarm with AXI4-Lite settings and status
//
// Function
// - Build each channel's distortion from its 32-component harmonic spectrum.
// - Spectra of five channels arrive every 5 ms; evaluate every completed set.
// - Common method setting: 1 amplitude ratio (default), 2 power ratio.
// - Capture distortion energies averaged over the 20 ms preceding an event.
// - Mode setting 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off; reported back.
// - Side select: 0 first current module (default), 1 second module.
// - Per-element enable, 0 enables, 1 disables; disabled never picks up.
// - Per-element threshold in 0.01 % steps, default 10.00 %, phases share one.
// - Phase element picks up when any phase exceeds the shared threshold.
// - Picked-up element drops out only below 97 % of its threshold.
// - START only when picked up and blocking inactive.
// - Blocking input sampled at the start of every evaluation.
// - Blocked at pick-up gives BLOCKED instead of START, no timing.
// - Blocking during START clears START and resets timing as on drop-out.
// - Blocking issues a display event and stamped event with fault type.
// - Forced-stage test lets a software switch drive blocking.
// - Definite-time delay per element, 5 ms steps, default 10 s.
// - Condition code 0 normal, 1 started, 2 alarm, 3 blocked.
// - Mode, side and method are static, outside the setting groups.
// - Separate START and ALARM per element, plus BLOCKED outputs.
// - Eight setting groups from one selector; active group applies.
// - Resettable START/ALARM/BLOCKED counters; ON/OFF events stamped at 1 ms.
`timescale 1ns/1ps
`default_nettype none

module thd_alarm
    import thd_pkg::*;
#(
    parameter int MS_CYC = MS_CYC_DEF   // Cycles per millisecond tick
) (
    input wire logic sys_clk,                       // 100 MHz clock
    input wire logic rst_n,                         // Async reset, active low
    input wire thd_pkg::axil_req_t axiReq,          // AXI4-Lite master signals
    output var thd_pkg::axil_rsp_t axiRsp,          // AXI4-Lite slave signals
    input wire thd_pkg::spec_beat_t specCt1,        // Spectra, first current module
    input wire thd_pkg::spec_beat_t specCt2,        // Spectra, second current module
    input wire logic blockIn,                       // Blocking from blocking matrix
    input wire logic [2:0] sgSel,                   // Active setting group
    output logic [thd_pkg::NEL-1:0] startOut,       // START per element
    output logic [thd_pkg::NEL-1:0] alarmOut,       // ALARM per element
    output logic [thd_pkg::NEL-1:0] blockedOut,     // BLOCKED per element
    output logic [1:0] condition,                   // Condition code
    output logic [2:0] modeOut,                     // Active function mode
    output var thd_pkg::evt_t evt                   // Event pulses and stamp
);
    import thd_pkg::*;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [NSG-1:0][SG_WORDS-1:0][DLY_W-1:0] sg;
        logic [NCH-1:0][ACC_W-1:0] accH;
        logic [NCH-1:0][SQ_W-1:0] accF;
        logic [NCH-1:0][ACC_W-1:0] totH;
        logic [NCH-1:0][SQ_W-1:0] totF;
        logic evalReq;
        logic [NCH-1:0] chPick;
        logic [NEL-1:0] start;
        logic [NEL-1:0] alarm;
        logic [NEL-1:0] blocked;
        logic [NEL-1:0][DLY_W-1:0] tmr;
        logic [31:0] msCnt;
        logic [2:0] stepCnt;
        logic [HIST_N-1:0][NCH-1:0][31:0] histH;
        logic [HIST_N-1:0][NCH-1:0][31:0] histF;
        logic [NCH-1:0][31:0] capH;
        logic [NCH-1:0][31:0] capF;
        logic [CNT_W-1:0] cntS;
        logic [CNT_W-1:0] cntA;
        logic [CNT_W-1:0] cntB;
        logic awHave;
        logic [ADDR_W-1:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        axil_rsp_t rsp;
        logic [1:0] cond;
        evt_t evt;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    function automatic state_t resetState();
        state_t v;
        v = '0;
        v.ctrl = CTRL_RST;
        for (int g = 0; g < NSG; g++) begin
            for (int e = 0; e < NEL; e++) begin
                v.sg[g][e] = DLY_W'(THR_DEF);
                v.sg[g][NEL + e] = DLY_W'(DLY_DEF);
            end
        end
        return v;
    endfunction

    function automatic logic [31:0] sat32(input logic [ACC_W-1:0] x);
        return (|x[ACC_W-1:32]) ? 32'hFFFF_FFFF : x[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Static settings and per-channel comparators

    logic [2:0] mode;
    logic powerMeth;
    logic modeOff;
    logic [NCH-1:0] pickC;
    logic [NCH-1:0] relC;

    assign mode = s_r.ctrl[CTRL_MODE_LSB +: 3];
    assign powerMeth = s_r.ctrl[CTRL_METH_LSB +: 2] == METH_POWER;
    assign modeOff = mode == MODE_OFF;

    // Ratio tests are done by cross-multiplication so no divider is needed;
    // the amplitude ratio is compared squared against the squared threshold.
    for (genvar ch = 0; ch < NCH; ch++) begin : g_cmp
        localparam int EL = (ch < NPH) ? 0 : ch - NPH + 1;
        logic [THR_W-1:0] thr;
        logic [CMP_W-1:0] tThr;
        logic [CMP_W-1:0] hk;
        logic [CMP_W-1:0] tf;
        assign thr = s_r.sg[sgSel][EL][THR_W-1:0];
        assign tThr = powerMeth ? CMP_W'(thr) : CMP_W'(thr) * CMP_W'(thr);
        assign hk = CMP_W'(s_r.totH[ch]) * CMP_W'(powerMeth ? SCALE_POW : SCALE_AMP);
        assign tf = tThr * CMP_W'(s_r.totF[ch]);
        assign pickC[ch] = hk > tf;
        assign relC[ch] = hk * CMP_W'(powerMeth ? REL_DEN : REL_DEN_SQ)
            < tf * CMP_W'(powerMeth ? REL_NUM : REL_NUM_SQ);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    logic tickMs;
    logic tick5;
    spec_beat_t beat;
    logic blk;
    logic [NEL-1:0] elPick;
    logic [NCH-1:0][SQ_W-1:0] sq;
    logic [NEV-1:0] prevV;
    logic [NEV-1:0] nextV;
    logic [33:0] sumH;
    logic [33:0] sumF;
    logic [31:0] rd;
    logic [1:0] rresp;
    logic [ADDR_W-1:0] ra;
    logic [ADDR_W-1:0] wa;
    logic [31:0] wv;
    logic [2:0] clrCnt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.evt.on = '0;
        s_nxt.evt.off = '0;
        s_nxt.evt.blkDisplay = 1'b0;
        s_nxt.evalReq = 1'b0;
        clrCnt = '0;
        sumH = '0;
        sumF = '0;
        rd = '0;
        rresp = RESP_OKAY;
        ra = axiReq.araddr;
        wa = s_r.awAddr;
        wv = s_r.ctrl;

        // Millisecond stamp and 5 ms timer step
        tickMs = s_r.msCnt == 32'(MS_CYC - 1);
        tick5 = tickMs && (s_r.stepCnt == 3'(SET_BASE_MS - 1));
        s_nxt.msCnt = tickMs ? '0 : s_r.msCnt + 32'h0000_0001;
        if (tickMs) begin
            s_nxt.evt.stamp = s_r.evt.stamp + 32'h0000_0001;
            s_nxt.stepCnt = tick5 ? '0 : s_r.stepCnt + 3'h1;
        end

        // Spectrum accumulation from the selected module
        beat = s_r.ctrl[CTRL_SIDE] ? specCt2 : specCt1;
        for (int ch = 0; ch < NCH; ch++) begin
            sq[ch] = SQ_W'(beat.mag[ch]) * SQ_W'(beat.mag[ch]);
            if (beat.valid) begin
                if (beat.idx == '0) begin
                    s_nxt.accF[ch] = sq[ch];
                    s_nxt.accH[ch] = '0;
                end else begin
                    s_nxt.accH[ch] = s_r.accH[ch] + ACC_W'(sq[ch]);
                end
                if (beat.idx == 5'(NCOMP - 1)) begin
                    s_nxt.totH[ch] = s_nxt.accH[ch];
                    s_nxt.totF[ch] = s_nxt.accF[ch];
                end
            end
        end
        s_nxt.evalReq = beat.valid && (beat.idx == 5'(NCOMP - 1));

        // Blocking sampled in the evaluation cycle itself
        blk = blockIn
            || (s_r.ctrl[CTRL_FORCE_EN] && s_r.ctrl[CTRL_FORCE_BLK])
            || mode == MODE_BLK || mode == MODE_TBLK;

        if (s_r.evalReq) begin
            for (int ch = 0; ch < NCH; ch++) begin
                s_nxt.chPick[ch] = !modeOff
                    && (s_r.chPick[ch] ? !relC[ch] : pickC[ch]);
            end
            for (int k = HIST_N - 1; k > 0; k--) begin
                s_nxt.histH[k] = s_r.histH[k - 1];
                s_nxt.histF[k] = s_r.histF[k - 1];
            end
            for (int ch = 0; ch < NCH; ch++) begin
                s_nxt.histH[0][ch] = sat32(s_r.totH[ch]);
                s_nxt.histF[0][ch] = s_r.totF[ch];
            end
        end
        elPick[0] = |s_nxt.chPick[NPH-1:0];
        elPick[1] = s_nxt.chPick[NPH];
        elPick[2] = s_nxt.chPick[NPH + 1];
        elPick = elPick & ~s_r.ctrl[CTRL_DIS_LSB +: NEL];
        if (s_r.evalReq) begin
            s_nxt.start = elPick & {NEL{!blk}};
            s_nxt.blocked = elPick & {NEL{blk}};
        end

        // Definite-time delay; a dropped START clears the timer and alarm
        for (int e = 0; e < NEL; e++) begin
            if (!s_nxt.start[e]) begin
                s_nxt.tmr[e] = '0;
            end else if (tick5 && s_r.tmr[e] < s_r.sg[sgSel][NEL + e]) begin
                s_nxt.tmr[e] = s_r.tmr[e] + DLY_W'(1);
            end
            s_nxt.alarm[e] = s_nxt.start[e]
                && s_nxt.tmr[e] >= s_r.sg[sgSel][NEL + e];
        end

        // Condition code, highest severity first
        if (|s_nxt.blocked) begin
            s_nxt.cond = COND_BLOCKED;
        end else if (|s_nxt.alarm) begin
            s_nxt.cond = COND_ALARM;
        end else if (|s_nxt.start) begin
            s_nxt.cond = COND_START;
        end else begin
            s_nxt.cond = COND_NORMAL;
        end

        // ON/OFF events, display event, counters
        prevV = {|s_r.blocked, s_r.alarm, s_r.start};
        nextV = {|s_nxt.blocked, s_nxt.alarm, s_nxt.start};
        s_nxt.evt.on = nextV & ~prevV;
        s_nxt.evt.off = prevV & ~nextV;
        if (s_nxt.evt.on[NEV-1]) begin
            s_nxt.evt.blkDisplay = 1'b1;
            s_nxt.evt.faultType = s_nxt.chPick;
        end
        // Pre-fault capture uses history from before this evaluation
        if (s_nxt.evt.on[NEV-1] || |s_nxt.evt.on[NEL-1:0]) begin
            for (int ch = 0; ch < NCH; ch++) begin
                sumH = '0;
                sumF = '0;
                for (int k = 0; k < HIST_N; k++) begin
                    sumH = sumH + 34'(s_r.histH[k][ch]);
                    sumF = sumF + 34'(s_r.histF[k][ch]);
                end
                s_nxt.capH[ch] = 32'(sumH >> HIST_SH);
                s_nxt.capF[ch] = 32'(sumF >> HIST_SH);
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // AXI4-Lite slave: write address and data in either order

        if (s_r.rsp.bvalid && axiReq.bready) begin
            s_nxt.rsp.bvalid = 1'b0;
        end
        if (axiReq.awvalid && s_r.rsp.awready) begin
            s_nxt.awHave = 1'b1;
            s_nxt.awAddr = axiReq.awaddr;
        end
        if (axiReq.wvalid && s_r.rsp.wready) begin
            s_nxt.wHave = 1'b1;
            s_nxt.wData = axiReq.wdata;
            s_nxt.wStrb = axiReq.wstrb;
        end
        if (s_r.awHave && s_r.wHave && !s_r.rsp.bvalid) begin
            s_nxt.awHave = 1'b0;
            s_nxt.wHave = 1'b0;
            s_nxt.rsp.bvalid = 1'b1;
            s_nxt.rsp.bresp = RESP_OKAY;
            if (wa[11:8] == SG_PAGE && int'(wa[4:2]) < SG_WORDS) begin
                wv = 32'(s_r.sg[wa[7:5]][wa[4:2]]);
            end
            for (int b = 0; b < 4; b++) begin
                if (s_r.wStrb[b]) begin
                    wv[8*b +: 8] = s_r.wData[8*b +: 8];
                end
            end
            if (wa == A_CTRL) begin
                s_nxt.ctrl = wv;
            end else if (wa == A_CNT_CLR) begin
                clrCnt = wv[2:0];
            end else if (wa[11:8] == SG_PAGE && int'(wa[4:2]) < SG_WORDS) begin
                s_nxt.sg[wa[7:5]][wa[4:2]] = (int'(wa[4:2]) < NEL)
                    ? DLY_W'(wv[THR_W-1:0]) : wv[DLY_W-1:0];
            end else begin
                s_nxt.rsp.bresp = RESP_SLVERR;
            end
        end
        s_nxt.rsp.awready = !s_nxt.awHave && !s_nxt.rsp.bvalid;
        s_nxt.rsp.wready = !s_nxt.wHave && !s_nxt.rsp.bvalid;

        // A new occurrence in the clearing cycle still counts once
        if (clrCnt[0]) s_nxt.cntS = '0;
        if (clrCnt[1]) s_nxt.cntA = '0;
        if (clrCnt[2]) s_nxt.cntB = '0;
        if (|s_nxt.evt.on[NEL-1:0]) s_nxt.cntS = s_nxt.cntS + CNT_W'(1);
        if (|s_nxt.evt.on[2*NEL-1:NEL]) s_nxt.cntA = s_nxt.cntA + CNT_W'(1);
        if (s_nxt.evt.on[NEV-1]) s_nxt.cntB = s_nxt.cntB + CNT_W'(1);

        if (s_r.rsp.rvalid && axiReq.rready) begin
            s_nxt.rsp.rvalid = 1'b0;
        end
        if (axiReq.arvalid && s_r.rsp.arready) begin
            case (ra)
                A_CTRL: rd = s_r.ctrl;
                A_STATUS: rd = {13'h0000, s_r.chPick, s_r.blocked, s_r.alarm,
                    s_r.start, mode, s_r.cond};
                A_CNT_START: rd = 32'(s_r.cntS);
                A_CNT_ALARM: rd = 32'(s_r.cntA);
                A_CNT_BLOCKED: rd = 32'(s_r.cntB);
                A_CNT_CLR: rd = '0;
                default: begin
                    if (ra[11:6] == CAP_PAGE && int'(ra[5:3]) < NCH) begin
                        rd = ra[2] ? s_r.capF[ra[5:3]] : s_r.capH[ra[5:3]];
                    end else if (ra[11:8] == SG_PAGE && int'(ra[4:2]) < SG_WORDS) begin
                        rd = 32'(s_r.sg[ra[7:5]][ra[4:2]]);
                    end else begin
                        rresp = RESP_SLVERR;
                    end
                end
            endcase
            s_nxt.rsp.rvalid = 1'b1;
            s_nxt.rsp.rdata = rd;
            s_nxt.rsp.rresp = rresp;
        end
        s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register and outputs

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= resetState();
        end else begin
            s_r <= s_nxt;
        end
    end

    assign axiRsp = s_r.rsp;
    assign startOut = s_r.start;
    assign alarmOut = s_r.alarm;
    assign blockedOut = s_r.blocked;
    assign condition = s_r.cond;
    assign modeOut = s_r.ctrl[CTRL_MODE_LSB +: 3];
    assign evt = s_r.evt;

endmodule // thd_alarm

`default_nettype wire

/* File: inc/thd_pkg.sv */
// Package: constants, register map and carrier types of the current distortion alarm
package thd_pkg;
    localparam int NCH = 5;            // Three phases, two residuals
    localparam int NEL = 3;            // Phase, residual 1, residual 2 elements
    localparam int NPH = 3;            // Phase channels share one element
    localparam int NCOMP = 32;         // Spectrum components per channel
    localparam int MAG_W = 16;
    localparam int SQ_W = 2 * MAG_W;
    localparam int ACC_W = SQ_W + 5;   // 31 harmonic squares summed
    localparam int CMP_W = 80;
    localparam int THR_W = 14;         // Threshold in 0.01 % steps
    localparam int DLY_W = 19;         // Delay in 5 ms steps, up to 1800 s
    localparam int NSG = 8;
    localparam int SG_WORDS = 6;       // Three thresholds, then three delays
    localparam int CNT_W = 16;
    localparam int NEV = 7;            // Start x3, alarm x3, blocked

    // Time base
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1_000_000;
    localparam int MS_CYC_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int SET_BASE_MS = 5;
    localparam int PREFAULT_MS = 20;
    localparam int HIST_N = PREFAULT_MS / SET_BASE_MS;
    localparam int HIST_SH = $clog2(HIST_N);

    // Ratio scaling: 10000 means a ratio of one at 0.01 % resolution
    localparam int SCALE_POW = 10000;
    localparam int SCALE_AMP = SCALE_POW * SCALE_POW;
    localparam int REL_NUM = 97;
    localparam int REL_DEN = 100;
    localparam int REL_NUM_SQ = REL_NUM * REL_NUM;
    localparam int REL_DEN_SQ = REL_DEN * REL_DEN;
    localparam int THR_DEF = 1000;     // 10.00 %
    localparam int DLY_DEF_MS = 10000;
    localparam int DLY_DEF = DLY_DEF_MS / SET_BASE_MS;

    // Setting encodings
    localparam logic [2:0] MODE_ON = 3'h1;
    localparam logic [2:0] MODE_BLK = 3'h2;
    localparam logic [2:0] MODE_TEST = 3'h3;
    localparam logic [2:0] MODE_TBLK = 3'h4;
    localparam logic [2:0] MODE_OFF = 3'h5;
    localparam logic [1:0] METH_POWER = 2'h2;
    localparam logic [1:0] COND_NORMAL = 2'h0;
    localparam logic [1:0] COND_START = 2'h1;
    localparam logic [1:0] COND_ALARM = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SIDE = 3;
    localparam int CTRL_METH_LSB = 4;
    localparam int CTRL_DIS_LSB = 6;
    localparam int CTRL_FORCE_EN = 9;
    localparam int CTRL_FORCE_BLK = 10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0011;

    // Register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_CNT_START = 12'h008;
    localparam logic [11:0] A_CNT_ALARM = 12'h00C;
    localparam logic [11:0] A_CNT_BLOCKED = 12'h010;
    localparam logic [11:0] A_CNT_CLR = 12'h014;
    localparam logic [5:0] CAP_PAGE = 6'h01;    // 0x040..0x07F, 8 bytes per channel
    localparam logic [3:0] SG_PAGE = 4'h1;      // 0x100..0x1FF, 0x20 per group
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic valid;
        logic [4:0] idx;                        // 0 fundamental, 1..31 harmonics
        logic [NCH-1:0][MAG_W-1:0] mag;
    } spec_beat_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [NEV-1:0] on;                     // {blocked, alarm[2:0], start[2:0]}
        logic [NEV-1:0] off;
        logic [31:0] stamp;                     // Milliseconds since reset
        logic blkDisplay;
        logic [NCH-1:0] faultType;
    } evt_t;
endpackage

/* File: dv/thd_checker.sv */
// Checker: port assertions of the distortion alarm
`timescale 1ns/1ps
`default_nettype none
module thd_checker
    import thd_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic rst_n, // Reset
    input wire thd_pkg::axil_req_t axiReq, // Bus in
    input wire thd_pkg::axil_rsp_t axiRsp, // Bus out
    input wire logic [2:0] startOut, // Start
    input wire logic [2:0] alarmOut, // Alarm
    input wire logic [2:0] blockedOut, // Blocked
    input wire logic [1:0] condition, // Code
    input wire thd_pkg::evt_t evt // Events
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_wr_both;
        axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready;
    endsequence
    a_start_blk_excl: assert property ((startOut & blockedOut) == 3'h0)
        else $error("start and blocked together");
    a_alarm_needs_start: assert property ((alarmOut & ~startOut) == 3'h0)
        else $error("alarm without start");
    a_code_blocked: assert property (|blockedOut |-> condition == COND_BLOCKED)
        else $error("code not blocked");
    a_code_alarm: assert property (!blockedOut && |alarmOut |-> condition == COND_ALARM)
        else $error("code not alarm");
    a_code_normal: assert property (
        !{startOut, alarmOut, blockedOut} |-> condition == COND_NORMAL)
        else $error("code not normal");
    a_start_on_evt: assert property ($rose(startOut[0]) |-> evt.on[0])
        else $error("no start event");
    a_start_off_evt: assert property ($fell(startOut[0]) |-> evt.off[0])
        else $error("no start off event");
    a_alarm_on_evt: assert property ($rose(alarmOut[0]) |-> evt.on[3])
        else $error("no alarm event");
    a_blk_display: assert property ($rose(|blockedOut) |-> evt.on[6] && evt.blkDisplay)
        else $error("no blocked events");
    a_write_resp: assert property (s_wr_both |-> ##2 axiRsp.bvalid)
        else $error("late write answer");
endmodule // thd_checker
bind thd_alarm thd_checker thd_checker_inst (.sys_clk, .rst_n, .axiReq, .axiRsp,
    .startOut, .alarmOut, .blockedOut, .condition, .evt);
`default_nettype wire

/* File: dv/spec_source.sv */
// Partner model: front end streaming one 32-component spectrum set per request
`timescale 1ns/1ps
`default_nettype none
module spec_source
    import thd_pkg::*;
(
    input wire logic sys_clk, // Clock
    input wire logic go, // Send one set
    input wire logic side, // 1 uses second module
    input wire logic [thd_pkg::NCH-1:0][15:0] harm, // First harmonic
    output var thd_pkg::spec_beat_t specCt1, // First module
    output var thd_pkg::spec_beat_t specCt2 // Second module
);
    int k = 32;
    logic [15:0] cyc = 16'h0000;
    spec_beat_t cur;
    spec_beat_t idle;
    // Idle lines toggle so a stale beat is never mistaken for data
    assign idle = {1'b0, cyc[4:0], {NCH{cyc}}};
    always @(posedge sys_clk) begin
        cyc <= cyc + 16'h0001;
        if (k < 32) k <= k + 1;
        else if (go) k <= 0;
    end
    always_comb begin
        cur.valid = k < 32;
        cur.idx = k[4:0];
        cur.mag = (k == 0) ? {NCH{16'h0064}} : (k == 1) ? harm : '0;
        if (!cur.valid) cur = idle;
    end
    assign specCt1 = side ? idle : cur;
    assign specCt2 = side ? cur : idle;
endmodule // spec_source
`default_nettype wire

/* File: dv/testbench.sv */
// Testbench: registers, pickup, timing and blocking of the distortion alarm
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import thd_pkg::*;
    logic sys_clk, rst_n, blockIn, go, side;
    logic [2:0] sgSel, startOut, alarmOut, blockedOut, modeOut;
    logic [1:0] condition, r;
    logic [31:0] d;
    logic [NCH-1:0][15:0] harm;
    axil_req_t axiReq;
    axil_rsp_t axiRsp;
    spec_beat_t specCt1, specCt2;
    evt_t evt;
    int errTotal = 0, nTests = 0;
    always #5 sys_clk = ~sys_clk;
    thd_alarm #(.MS_CYC(10)) thd_alarm_inst (.sys_clk, .rst_n, .axiReq, .axiRsp, .specCt1,
        .specCt2, .blockIn, .sgSel, .startOut, .alarmOut, .blockedOut, .condition, .modeOut, .evt);
    spec_source spec_source_inst (.sys_clk, .go, .side, .harm, .specCt1, .specCt2);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        axiReq.awvalid <= 1'b1;
        axiReq.awaddr <= a;
        axiReq.wvalid <= 1'b1;
        axiReq.wdata <= v;
        do begin
            @(posedge sys_clk);
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (!axiRsp.bvalid);
    endtask
    task automatic rd(input logic [11:0] a);
        axiReq.arvalid <= 1'b1;
        axiReq.araddr <= a;
        do begin
            @(posedge sys_clk);
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (!axiRsp.rvalid);
        d = axiRsp.rdata;
        r = axiRsp.rresp;
    endtask
    // Fundamental 100: amplitude 10 % needs H over 100, power 10 % H over 1000
    // e holds {mask, expected {condition, blocked, start}}
    task automatic step(input logic [11:0] c, input logic [4:0] b, input int ch,
            input logic [15:0] h, input logic [15:0] e);
        logic [NCH-1:0][15:0] v;
        v = '0;
        v[ch] = h;
        wr(A_CTRL, {20'h0_0000, c});
        {blockIn, side, sgSel} <= b;
        harm <= v;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        repeat (35) @(posedge sys_clk);
        chk({condition, blockedOut, startOut} & e[15:8], e[7:0]);
    endtask
    task automatic t_regs;
        rd(A_CTRL);
        chk(d, CTRL_RST);
        rd(12'h100);
        chk(d, THR_DEF);
        rd(12'h10C);
        chk(d, DLY_DEF);
        rd(12'h018);
        chk(r, RESP_SLVERR);
        for (int m = 1; m <= 5; m++) begin
            wr(A_CTRL, 32'h0000_0010 | m);
            repeat (2) @(posedge sys_clk);
            chk(modeOut, m);
        end
    endtask
    task automatic t_timing;
        wr(12'h10C, 32'h0000_0002);
        step(12'h011, 5'h00, 1, 16'h000B, 16'hFF41);
        repeat (30) @(posedge sys_clk);
        chk(alarmOut, 3'h0);
        d = evt.stamp;
        repeat (80) @(posedge sys_clk);
        chk({condition, alarmOut}, 5'h11);
        chk(evt.stamp - d, 32'h0000_0008);
        step(12'h011, 5'h00, 1, 16'h000A, 16'hFF81);
        step(12'h011, 5'h00, 1, 16'h0009, 16'hFF00);
    endtask
    task automatic t_control;
        step(12'h021, 5'h00, 3, 16'h0014, 16'hFF00);
        step(12'h011, 5'h00, 3, 16'h0014, 16'hFF42);
        step(12'h111, 5'h00, 4, 16'h0014, 16'hFF00);
        step(12'h019, 5'h00, 4, 16'h0014, 16'hFF00);
        step(12'h019, 5'h08, 4, 16'h0014, 16'hFF44);
        step(12'h011, 5'h10, 4, 16'h0014, 16'h0700);
        step(12'h011, 5'h00, 4, 16'h0014, 16'hFF44);
        step(12'h611, 5'h00, 4, 16'h0014, 16'h3F20);
        step(12'h011, 5'h00, 4, 16'h0000, 16'hFF00);
        step(12'h011, 5'h10, 4, 16'h0014, 16'hFFE0);
        wr(12'h120, 32'h0000_1388);
        step(12'h011, 5'h01, 0, 16'h000B, 16'hFF00);
        step(12'h011, 5'h00, 0, 16'h000B, 16'hFF41);
    endtask
    // Counters, pre-fault capture, mode-driven blocking and the off mode
    task automatic t_extra;
        wr(A_CNT_CLR, 32'h0000_0007);
        rd(A_CNT_START);
        chk(d, 32'h0000_0000);
        step(12'h012, 5'h00, 3, 16'h0014, 16'hFFD0);
        chk(evt.faultType, 5'h08);
        step(12'h011, 5'h00, 3, 16'h0014, 16'hFF42);
        rd(A_CNT_START);
        chk(d, 32'h0000_0001);
        rd(A_CNT_BLOCKED);
        chk(d, 32'h0000_0001);
        rd(12'h058);
        chk(d, 32'h0000_0064);
        rd(12'h05C);
        chk(d, 32'h0000_2710);
        step(12'h015, 5'h00, 3, 16'h0014, 16'hFF00);
    endtask
    task automatic give_verdict;
        $display("Checks %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        axiReq = '{bready: 1'b1, rready: 1'b1, wstrb: 4'hF, default: '0};
        {blockIn, side, sgSel, go} = 6'h00;
        harm = '0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_regs;
        t_timing;
        t_control;
        t_extra;
        give_verdict;
    end
    initial begin
        #100_000;
        errTotal++;
        give_verdict;
    end
endmodule // testbench
`default_nettype wire
